// *** rtl/spi_port.sv ***
// Contract
// - slave selected drives miso only when its direction bit is output.
// - slave deselect resets bit counter, shift logic, drops partial byte.
// - master with ss as output: ss is a plain output.
// - master with ss input low clears role bit, becomes slave.
// - that fallback also sets transfer done, may raise interrupt.
// - data shifted and sampled on opposite sck edges, four modes.
// - clock idle level bit selects sck idle level.
// - clock phase bit selects sample on leading or trailing edge.
// - interrupt asserted while done flag, enable and global enable.
// - port enable bit gates all serial operation.
// - bit order bit selects lsb first or msb first.
// - role bit one master, zero slave.
// - rate bits with double rate select master sck divider.
// - rate and double rate bits ignored in slave role.
// - done flag set when a byte transfer finishes.
// - done clears on vector ack or status read then data access.
// - collision flag set on data write during transfer.
// - status read with collision then data access clears both flags.
// - status bits five to one read zero.
// - data write starts transfer, data read returns received byte.
// - transmit single buffered, receive double buffered.
// - master gives exactly eight sck pulses then stops, sets done.
//
// The APB interface to the registers was decided locally.
`default_nettype none
module spi_port
  import spi_port_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               global_irq_en,
  input  wire logic               irq_ack,
  output logic                    irq,
  input  wire logic               sck_i,
  output logic                    sck_o,
  output logic                    sck_oe,
  input  wire logic               mosi_i,
  output logic                    mosi_o,
  output logic                    mosi_oe,
  input  wire logic               miso_i,
  output logic                    miso_o,
  output logic                    miso_oe,
  input  wire logic               ss_n_i,
  output logic                    ss_n_o,
  output logic                    ss_n_oe
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        dbl;
    logic        done;
    logic        col;
    logic [4:0]  pins;
    logic        arm_done;
    logic        arm_col;
    logic        busy;
    logic [4:0]  edges;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic        lat;
    logic        have;
    logic [7:0]  rx;
    logic        sck_lv;
    logic        sck_prev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        sck_o;
    logic        sck_oe;
    logic        mosi_o;
    logic        mosi_oe;
    logic        miso_o;
    logic        miso_oe;
    logic        ss_o;
    logic        ss_oe;
  } port_s;

  port_s       q, n;
  logic [3:0]  pin_s;
  logic        sck_s, mosi_s, miso_s, ss_s;
  logic        half_tick;

  // ****************************************
  // pin synchronisers and master clock divider
  // ****************************************
  spi_pin_sync #(.W(4), .RST(4'h8)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({ss_n_i, miso_i, mosi_i, sck_i}),
    .pin_sync (pin_s)
  );

  assign sck_s  = pin_s[0];
  assign mosi_s = pin_s[1];
  assign miso_s = pin_s[2];
  assign ss_s   = pin_s[3];

  // divider only runs in master transfers, so rate bits are dead in slave role
  spi_rate_div u_div (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .run       (q.busy),
    .rate_sel  ({q.dbl, q.ctrl[RATE_HI_BIT], q.ctrl[RATE_LO_BIT]}),
    .half_tick (half_tick)
  );

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b, input logic lsbf);
    shift_in = lsbf ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // ****************************************
  // decode and helper terms
  // ****************************************
  logic        en, master, clock_idle_level, clock_sample_phase, lsbf;
  logic        apb_setup, apb_access, sel_ctrl, sel_stat, sel_data, sel_pin;
  logic        wr_data, rd_stat, data_acc, busy_now, slave_act;
  logic        edge_ev, leading, sample, setup, in_bit, tx_bit, fallback;
  logic [31:0] rdval;

  assign en         = q.ctrl[PORT_EN_BIT];
  assign master     = q.ctrl[ROLE_BIT];
  assign clock_idle_level       = q.ctrl[IDLE_BIT];
  assign clock_sample_phase       = q.ctrl[PHASE_BIT];
  assign lsbf       = q.ctrl[ORDER_BIT];
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable & q.pready;
  assign sel_ctrl   = (paddr == CTRL_ADDR);
  assign sel_stat   = (paddr == STAT_ADDR);
  assign sel_data   = (paddr == DATA_ADDR);
  assign sel_pin    = (paddr == PIN_ADDR);
  assign wr_data    = apb_access & pwrite & sel_data;
  assign rd_stat    = apb_access & ~pwrite & sel_stat;
  assign data_acc   = apb_access & sel_data;
  assign slave_act  = en & ~master & ~ss_s;
  assign busy_now   = (master & q.busy) | (slave_act & ((q.bits != 4'h0) | q.have));
  // master counts its own half periods, slave watches synchronised sck
  assign edge_ev    = master ? (q.busy & half_tick) : (slave_act & (sck_s != q.sck_prev));
  assign leading    = master ? ~q.edges[0] : (sck_s != clock_idle_level);
  assign sample     = edge_ev & (leading ^ clock_sample_phase);
  assign setup      = edge_ev & ~(leading ^ clock_sample_phase);
  assign in_bit     = master ? miso_s : mosi_s;
  assign fallback   = en & master & ~q.pins[SS_DIR] & ~ss_s;

  always_comb begin
    rdval = 32'h0000_0000;
    if (sel_ctrl) begin
      rdval[7:0] = q.ctrl;
    end else if (sel_stat) begin
      rdval[7:0] = {q.done, q.col, 5'h00, q.dbl};
    end else if (sel_data) begin
      rdval[7:0] = q.rx;
    end else if (sel_pin) begin
      rdval[4:0] = q.pins;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n         = q;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    tx_bit    = 1'b0;
    // no wait state: read data and error are prepared in the setup cycle
    if (apb_setup) begin
      n.pready  = 1'b1;
      n.pslverr = ~(sel_ctrl | sel_stat | sel_data | sel_pin);
      n.prdata  = rdval;
    end
    if (apb_access & pwrite & sel_ctrl) begin
      n.ctrl = pwdata[7:0];
    end
    if (apb_access & pwrite & sel_stat) begin
      n.dbl = pwdata[DBL_BIT];
    end
    if (apb_access & pwrite & sel_pin) begin
      n.pins = pwdata[4:0];
    end
    // clears come first so that a set in the same cycle wins
    if (data_acc) begin
      if (q.arm_done) begin
        n.done = 1'b0;
      end
      if (q.arm_col) begin
        n.col  = 1'b0;
        n.done = 1'b0;
      end
      n.arm_done = 1'b0;
      n.arm_col  = 1'b0;
    end
    if (rd_stat) begin
      n.arm_done = q.done;
      n.arm_col  = q.col;
    end
    if (irq_ack) begin
      n.done = 1'b0;
    end
    n.sck_prev = sck_s;
    if (!q.busy) begin
      n.sck_lv = clock_idle_level;
    end
    // a write during a transfer is dropped, the shifter holds the only copy
    if (wr_data) begin
      if (busy_now) begin
        n.col = 1'b1;
      end else begin
        n.sh = pwdata[7:0];
        if (en & master) begin
          n.busy  = 1'b1;
          n.edges = 5'h00;
          n.bits  = 4'h0;
          n.have  = 1'b0;
        end
      end
    end
    // sampled bit waits in a latch until the opposite edge shifts it in
    if (sample) begin
      n.lat  = in_bit;
      n.have = 1'b1;
      n.bits = q.bits + 4'h1;
      if (q.bits == LAST_BIT) begin
        // shifter left alone here: the out line must not move on a sample edge
        n.rx   = shift_in(q.sh, in_bit, lsbf);
        n.have = 1'b0;
        n.bits = 4'h0;
        if (!master) begin
          n.done = 1'b1;
        end
      end
    end
    if (setup & q.have) begin
      n.sh   = shift_in(q.sh, q.lat, lsbf);
      n.have = 1'b0;
    end
    if (q.busy & half_tick) begin
      n.edges  = q.edges + 5'h01;
      n.sck_lv = ~q.sck_lv;
      if (q.edges == LAST_EDGE) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
    // deselected slave forgets any partial byte
    if (!master & (ss_s | !en)) begin
      n.bits = 4'h0;
      n.have = 1'b0;
    end
    if (!en) begin
      n.busy = 1'b0;
      n.bits = 4'h0;
      n.have = 1'b0;
    end
    if (fallback) begin
      n.ctrl[ROLE_BIT] = 1'b0;
      n.done           = 1'b1;
      n.busy           = 1'b0;
      n.bits           = 4'h0;
      n.have           = 1'b0;
    end
    // pin outputs follow the next state so they leave straight from flops
    tx_bit    = n.ctrl[ORDER_BIT] ? n.sh[0] : n.sh[7];
    n.sck_o   = n.sck_lv;
    n.sck_oe  = n.ctrl[PORT_EN_BIT] & n.ctrl[ROLE_BIT] & n.pins[SCK_DIR];
    n.mosi_o  = tx_bit;
    n.mosi_oe = n.ctrl[PORT_EN_BIT] & n.ctrl[ROLE_BIT] & n.pins[MOSI_DIR];
    n.miso_o  = tx_bit;
    n.miso_oe = n.ctrl[PORT_EN_BIT] & ~n.ctrl[ROLE_BIT] & ~ss_s & n.pins[MISO_DIR];
    n.ss_o    = n.pins[SS_OUT];
    n.ss_oe   = n.pins[SS_DIR] & ~(n.ctrl[PORT_EN_BIT] & ~n.ctrl[ROLE_BIT]);
    n.irq     = n.done & n.ctrl[IRQ_EN_BIT] & global_irq_en;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q        <= '0;
      q.ctrl   <= CTRL_RST;
      q.pins   <= PIN_RST;
      q.sh     <= DATA_RST;
      q.rx     <= DATA_RST;
      q.sck_o  <= 1'b0;
      q.mosi_o <= 1'b0;
      q.miso_o <= 1'b0;
    end else begin
      q <= n;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign irq     = q.irq;
  assign sck_o   = q.sck_o;
  assign sck_oe  = q.sck_oe;
  assign mosi_o  = q.mosi_o;
  assign mosi_oe = q.mosi_oe;
  assign miso_o  = q.miso_o;
  assign miso_oe = q.miso_oe;
  assign ss_n_o  = q.ss_o;
  assign ss_n_oe = q.ss_oe;

  // ****************************************
  // checks
  // ****************************************
  chk_collision_set: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_data && busy_now |=> q.col)
    else $error("collision flag not set on busy write");

  chk_fallback_role: assert property (@(posedge core_clk) disable iff (!rstn)
    fallback |=> !q.ctrl[ROLE_BIT] && !q.busy)
    else $error("role bit not cleared by low ss");

  chk_fallback_done: assert property (@(posedge core_clk) disable iff (!rstn)
    fallback |=> q.done ##1 (q.irq == (q.done && q.ctrl[IRQ_EN_BIT] && $past(global_irq_en))))
    else $error("fallback did not set done flag");

  chk_irq_cause: assert property (@(posedge core_clk) disable iff (!rstn)
    q.irq |-> q.done && q.ctrl[IRQ_EN_BIT])
    else $error("interrupt without done flag and enable");

  chk_status_reserved: assert property (@(posedge core_clk) disable iff (!rstn)
    apb_setup && sel_stat |=> q.pready && (q.prdata[5:1] == 5'h00))
    else $error("reserved status bits not zero");

  chk_slave_deselect: assert property (@(posedge core_clk) disable iff (!rstn)
    !master && ss_s |=> q.bits == 4'h0 && !q.have)
    else $error("slave kept partial byte after deselect");

  chk_eight_pulses: assert property (@(posedge core_clk) disable iff (!rstn)
    q.busy && half_tick && q.edges == LAST_EDGE && !fallback && en |=> !q.busy && q.done && q.sck_lv == $past(clock_idle_level))
    else $error("master did not stop after eight pulses");

  chk_sck_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    !q.busy ##1 !q.busy |-> q.sck_lv == $past(clock_idle_level))
    else $error("sck not at idle level");

  chk_miso_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    q.miso_oe |-> q.pins[MISO_DIR] && !q.ctrl[ROLE_BIT] && q.ctrl[PORT_EN_BIT])
    else $error("miso driven outside selected slave");

  chk_port_off: assert property (@(posedge core_clk) disable iff (!rstn)
    !en ##1 !en |-> !q.busy && !q.sck_oe && !q.mosi_oe && !q.miso_oe)
    else $error("activity while port disabled");

endmodule
`default_nettype wire

// *** rtl/spi_port_pkg.sv ***
`default_nettype none
package spi_port_pkg;

  // ****************************************
  // register map: printed offsets are word indices
  // ****************************************
  localparam int unsigned    ADDR_W      = 12;
  localparam logic [7:0]     CTRL_IDX    = 8'h2c;
  localparam logic [7:0]     STAT_IDX    = 8'h2d;
  localparam logic [7:0]     DATA_IDX    = 8'h2e;
  localparam logic [7:0]     PIN_IDX     = 8'h2f;
  localparam logic [11:0]    CTRL_ADDR   = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [11:0]    STAT_ADDR   = {2'b00, STAT_IDX, 2'b00};
  localparam logic [11:0]    DATA_ADDR   = {2'b00, DATA_IDX, 2'b00};
  localparam logic [11:0]    PIN_ADDR    = {2'b00, PIN_IDX, 2'b00};

  // ****************************************
  // control fields
  // ****************************************
  localparam int unsigned    IRQ_EN_BIT  = 7;
  localparam int unsigned    PORT_EN_BIT = 6;
  localparam int unsigned    ORDER_BIT   = 5;
  localparam int unsigned    ROLE_BIT    = 4;
  localparam int unsigned    IDLE_BIT    = 3;
  localparam int unsigned    PHASE_BIT   = 2;
  localparam int unsigned    RATE_HI_BIT = 1;
  localparam int unsigned    RATE_LO_BIT = 0;

  // ****************************************
  // status and pin-direction fields
  // ****************************************
  localparam int unsigned    DONE_BIT    = 7;
  localparam int unsigned    COL_BIT     = 6;
  localparam int unsigned    DBL_BIT     = 0;
  localparam int unsigned    MOSI_DIR    = 0;
  localparam int unsigned    SCK_DIR     = 1;
  localparam int unsigned    MISO_DIR    = 2;
  localparam int unsigned    SS_DIR      = 3;
  localparam int unsigned    SS_OUT      = 4;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0]     CTRL_RST    = 8'h00;
  localparam logic [4:0]     PIN_RST     = 5'h00;
  localparam logic [7:0]     DATA_RST    = 8'h00;
  localparam logic [4:0]     LAST_EDGE   = 5'h0f;
  localparam logic [3:0]     LAST_BIT    = 4'h7;
  // half sck period in core clocks, index {double_rate, rate_hi, rate_lo}
  localparam logic [6:0]     HALF_CYC [8] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                              7'h01, 7'h04, 7'h10, 7'h20};

endpackage
`default_nettype wire

// *** rtl/spi_pin_sync.sv ***
`default_nettype none
module spi_pin_sync
  import spi_port_pkg::*;
#(
  parameter int unsigned    W   = 4,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic [W-1:0]  pin_in,
  output logic [W-1:0]       pin_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s q, n;

  // first stage feeds only the second stage
  always_comb begin
    n    = q;
    n.s1 = pin_in;
    n.s2 = q.s1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{s1: RST, s2: RST};
    end else begin
      q <= n;
    end
  end

  assign pin_sync = q.s2;

endmodule
`default_nettype wire

// *** rtl/spi_rate_div.sv ***
`default_nettype none
module spi_rate_div
  import spi_port_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic [2:0]  rate_sel,
  output logic             half_tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } div_s;

  div_s q, n;

  always_comb begin
    n      = q;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 7'h00;
    end else if (q.cnt == HALF_CYC[rate_sel] - 7'h01) begin
      n.cnt  = 7'h00;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign half_tick = q.tick;

endmodule
`default_nettype wire

// *** sim/spi_peer_model.sv ***
`default_nettype none
module spi_peer_model (
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        ss_n,
  input  wire logic        clock_idle_level,
  input  wire logic        clock_sample_phase,
  input  wire logic        lsb,
  input  wire logic [7:0]  tx_byte,
  output logic             miso,
  output logic [7:0]       rx_byte,
  output int               edges
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // external serial peripheral
  // ****************************************
  int oi;
  int ii;

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    edges = 0;
    oi = 0;
    ii = 0;
  end

  // past the eighth bit the line is junk, never a stable copy
  function automatic logic pick(input int i);
    return (i > 7) ? ~miso : tx_byte[lsb ? i : 7 - i];
  endfunction

  always @(negedge ss_n) begin
    edges = 0;
    ii = 0;
    oi = 0;
    if (!clock_sample_phase) begin
      miso = pick(0);
      oi = 1;
    end
  end

  // released line: inverse of last value so a stale bit cannot pass
  always @(posedge ss_n) miso = ~miso;

  always @(sck) begin
    if (ss_n === 1'b0) begin
      edges++;
      if (sck ^ clock_idle_level ^ clock_sample_phase) begin
        if (ii < 8) rx_byte[lsb ? ii : 7 - ii] = mosi;
        ii++;
      end else begin
        miso = pick(oi);
        oi++;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, a, e); end end
module tb_top
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, rstn, psel, penable, pwrite, global_irq_en, irq_ack, ss_drv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr, irq, clock_idle_level, clock_sample_phase, lsb, sck_prev;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, miso_peer;
  logic        sck_ext, mosi_ext;
  logic [7:0]  tx, rx, sgot;
  int          n_mismatch, n_checks, edges, half, cyc;
  // undriven sck and mosi show the bench's external master, undriven slave select follows ss_drv from the bench
  wire logic   sck_line  = sck_oe ? sck_o : sck_ext;
  wire logic   mosi_line = mosi_oe ? mosi_o : mosi_ext;
  wire logic   miso_line = miso_oe ? miso_o : miso_peer;
  wire logic   ss_line   = ss_n_oe ? ss_n_o : ss_drv;
  localparam int HALF [8] = '{2, 8, 32, 64, 1, 4, 16, 32};

  spi_port dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq(irq), .sck_i(sck_line), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_i(mosi_line), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_line),
    .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_line), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));

  spi_peer_model peer (.sck(sck_line), .mosi(mosi_line), .ss_n(ss_line), .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase),
    .lsb(lsb), .tx_byte(tx), .miso(miso_peer), .rx_byte(rx), .edges(edges));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // cycles between the last two sck toggles
  always @(posedge core_clk) begin
    cyc++;
    if (sck_o !== sck_prev) begin
      half = cyc;
      cyc = 0;
    end
    sck_prev = sck_o;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask

  // external master on a selected slave, msb first, mode 0; miso taken at each rising edge
  task automatic slv_bits(input logic [7:0] m, input int nb);
    for (int i = 0; i < nb; i++) begin
      mosi_ext <= m[7 - i];
      repeat (6) @(posedge core_clk);
      sgot[7 - i] = miso_line;
      sck_ext <= 1'b1;
      repeat (6) @(posedge core_clk);
      sck_ext <= 1'b0;
    end
  endtask

  task automatic wait_done();
    repeat (2000) begin
      apb(1'b0, STAT_ADDR, 32'h0);
      if (rdat[DONE_BIT] === 1'b1) break;
    end
  endtask

  // one master byte with the peer selected; col adds a write while busy
  task automatic xfer(input logic [7:0] c, input logic dbl, input logic [7:0] d, input logic [7:0] s,
                      input logic col);
    clock_idle_level <= c[IDLE_BIT];
    clock_sample_phase <= c[PHASE_BIT];
    lsb <= c[ORDER_BIT];
    tx <= s;
    apb(1'b1, STAT_ADDR, {31'h0, dbl});
    apb(1'b1, CTRL_ADDR, {24'h0, c});
    apb(1'b1, PIN_ADDR, 32'h0000_000b);
    apb(1'b1, DATA_ADDR, {24'h0, d});
    if (col) apb(1'b1, DATA_ADDR, {24'h0, ~d});
    `CHK(ss_n_o, 1'b0)
    wait_done();
    `CHK(rdat, {24'h0, 1'b1, col, 5'h00, dbl})
    `CHK(irq, c[IRQ_EN_BIT] & global_irq_en)
    `CHK(edges, 16)
    `CHK(rx, d)
    `CHK(half, HALF[{dbl, c[1:0]}])
    `CHK(sck_o, c[IDLE_BIT])
    rd_chk(DATA_ADDR, {24'h0, s});
    rd_chk(STAT_ADDR, {31'h0, dbl});
    apb(1'b1, PIN_ADDR, 32'h0000_001b);
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    global_irq_en = 1'b0;
    irq_ack = 1'b0;
    ss_drv = 1'b1;
    sck_ext = 1'b0;
    mosi_ext = 1'b0;
    clock_idle_level = 1'b0;
    clock_sample_phase = 1'b0;
    lsb = 1'b0;
    tx = 8'h00;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    half = 0;
    sck_prev = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(CTRL_ADDR, 32'h0000_0000);
    rd_chk(STAT_ADDR, 32'h0000_0000);
    apb(1'b0, 12'hff0, 32'h0);
    `CHK(rerr, 1'b1)
    apb(1'b1, STAT_ADDR, 32'h0000_00ff);
    rd_chk(STAT_ADDR, 32'h0000_0001);
    apb(1'b1, STAT_ADDR, 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_0040);
    apb(1'b1, PIN_ADDR, 32'h0000_0004);
    ss_drv <= 1'b0;
    repeat (5) @(posedge core_clk);
    `CHK(miso_oe, 1'b1)
    `CHK(sck_oe, 1'b0)
    ss_drv <= 1'b1;
    repeat (5) @(posedge core_clk);
    `CHK(miso_oe, 1'b0)
    ss_drv <= 1'b0;
    repeat (4) @(posedge core_clk);
    slv_bits(8'hf0, 3);
    ss_drv <= 1'b1;
    repeat (4) @(posedge core_clk);
    apb(1'b1, DATA_ADDR, 32'h0000_00a5);
    ss_drv <= 1'b0;
    repeat (4) @(posedge core_clk);
    slv_bits(8'h3c, 8);
    repeat (8) @(posedge core_clk);
    `CHK(sgot, 8'ha5)
    rd_chk(STAT_ADDR, 32'h0000_0080);
    rd_chk(DATA_ADDR, 32'h0000_003c);
    ss_drv <= 1'b1;
    apb(1'b1, CTRL_ADDR, 32'h0000_0011);
    apb(1'b1, PIN_ADDR, 32'h0000_000b);
    apb(1'b1, DATA_ADDR, 32'h0000_0077);
    repeat (100) @(posedge core_clk);
    rd_chk(STAT_ADDR, 32'h0000_0000);
    `CHK(edges, 0)
    apb(1'b1, PIN_ADDR, 32'h0000_001b);
    for (int m = 0; m < 4; m++) begin
      global_irq_en <= m[0];
      xfer(8'(8'h50 + m * 4 + (m % 2) * 32 + (m > 0 ? 8'h80 + m : 8'h01)), 1'(m / 2),
           8'(8'h5a + m * 17), 8'(8'hc3 ^ m), 1'b0);
    end
    xfer(8'h51, 1'b0, 8'h3c, 8'h99, 1'b1);
    global_irq_en <= 1'b1;
    apb(1'b1, CTRL_ADDR, 32'h0000_00d1);
    apb(1'b1, PIN_ADDR, 32'h0000_0003);
    ss_drv <= 1'b0;
    repeat (5) @(posedge core_clk);
    rd_chk(CTRL_ADDR, 32'h0000_00c1);
    `CHK(sck_oe, 1'b0)
    `CHK(mosi_oe, 1'b0)
    rd_chk(STAT_ADDR, 32'h0000_0080);
    `CHK(irq, 1'b1)
    ss_drv <= 1'b1;
    repeat (4) @(posedge core_clk);
    irq_ack <= 1'b1;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    rd_chk(STAT_ADDR, 32'h0000_0000);
    `CHK(irq, 1'b0)
    apb(1'b1, CTRL_ADDR, 32'h0000_0051);
    rd_chk(CTRL_ADDR, 32'h0000_0051);
    complete_run();
  end
endmodule
`default_nettype wire
